// ### rtl/adc_seq_map.vh
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// Selection register field layout
`define SEL_CH_LSB 0
`define SEL_CH_MSB 3
`define SEL_REF_LSB 6
`define SEL_REF_MSB 7
`define SEL_RESET 8'h00
// Reference encodings
`define REF_PIN 2'h0
`define REF_SUPPLY 2'h1
`define REF_RESERVED 2'h2
`define REF_INTERNAL 2'h3
// Channel encodings
`define CH_TEMP 4'h8
`define CH_BANDGAP 4'he
`define CH_GROUND 4'hf
// Result codes
`define RESULT_ZERO 10'h000
`define RESULT_FULL 10'h3ff
`define RESULT_SCALE 1024
// Conversion lengths in converter clock cycles
`define CONV_CYCLES 13
`define FIRST_CONV_CYCLES 25
// Converter cycle index at which the sample is taken
`define SH_NORMAL 5'h01
`define SH_FIRST 5'h0d
`endif

// ### rtl/adc_sequencer.v
`include "adc_seq_map.vh"
`default_nettype none

module adc_sequencer #(
  parameter CONV_LEN = `CONV_CYCLES,
  parameter FIRST_LEN = `FIRST_CONV_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Converter clock tick from the prescaler, same clock domain
  input wire conv_tick,
  // Selection register access
  input wire sel_write,
  input wire [7:0] sel_wdata,
  output reg [7:0] selection_register,
  // Control
  input wire converter_enable,
  input wire start_write,
  input wire auto_trigger_enable,
  input wire trigger_edge,
  input wire done_clear,
  // Sleep
  input wire sleep_noise_or_idle,
  input wire cpu_halted,
  // Analog core
  input wire [9:0] sar_code,
  output reg [3:0] channel_select_bits,
  output reg [1:0] reference_select_bits,
  output reg sample_hold,
  // Status and result
  output reg start_conversion_bit,
  output reg conversion_done_flag,
  output reg done_irq_pulse,
  output reg [7:0] result_low_register,
  output reg [7:0] result_high_register
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_CONV = 2'h2;

  reg [1:0] state;
  reg [4:0] cnt;
  reg [4:0] conv_len;
  reg first_done;
  reg sleep_armed;
  reg sleep_started;
  reg pending;

  ////////////////////////////////////////////////////////////////////////////
  // True while the counter stands in the final converter cycle of a conversion
  function last_step;
    input [4:0] count;
    input [4:0] length;
    begin
      last_step = (count == length - 5'h01);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The lock spans the whole conversion except its final converter cycle.
  // The sampling phase therefore never sees a CPU write, while a write made
  // during the conversion is already applied when the next one starts.
  wire last_cycle = (state == ST_CONV) && conv_tick && last_step(cnt, conv_len);
  wire lock = (state == ST_CONV) && !last_step(cnt, conv_len);
  // Sleep start is held back in auto mode: the trigger owns the start then
  wire sleep_go = sleep_noise_or_idle && cpu_halted && sleep_armed && !auto_trigger_enable;
  wire req = start_write || sleep_go || (auto_trigger_enable && trigger_edge);

  ////////////////////////////////////////////////////////////////////////////
  // Buffered selection; reads see this copy
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      selection_register <= `SEL_RESET;
    end else if (sel_write) begin
      selection_register <= sel_wdata & 8'hcf;
    end
  end

  // Applied selection follows buffer while the converter is enabled and not locked
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_select_bits <= 4'h0;
      reference_select_bits <= `REF_PIN;
    end else if (converter_enable && !lock) begin
      channel_select_bits <= selection_register[`SEL_CH_MSB:`SEL_CH_LSB];
      reference_select_bits <= selection_register[`SEL_REF_MSB:`SEL_REF_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep start is armed once per sleep entry so it fires only once.
  // Limitation: a sleep entered while busy does not start a second conversion.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_armed <= 1'b0;
    end else if (!sleep_noise_or_idle) begin
      sleep_armed <= 1'b1;
    end else if (sleep_go) begin
      sleep_armed <= 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      conv_len <= FIRST_LEN[4:0];
      first_done <= 1'b0;
      start_conversion_bit <= 1'b0;
      conversion_done_flag <= 1'b0;
      done_irq_pulse <= 1'b0;
      sample_hold <= 1'b0;
      sleep_started <= 1'b0;
      pending <= 1'b0;
      result_low_register <= 8'h00;
      result_high_register <= 8'h00;
    end else begin
      done_irq_pulse <= 1'b0;
      sample_hold <= 1'b0;
      // Set wins over clear on the done flag
      if (last_cycle) begin
        conversion_done_flag <= 1'b1;
      end else if (done_clear) begin
        conversion_done_flag <= 1'b0;
      end
      if (!converter_enable) begin
        // Disabling aborts; apart from reset it is the only path that ends a conversion early
        state <= ST_IDLE;
        start_conversion_bit <= 1'b0;
        first_done <= 1'b0;
        sleep_started <= 1'b0;
        pending <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (req) begin
              state <= ST_ARMED;
              start_conversion_bit <= 1'b1;
              sleep_started <= sleep_go;
            end
          end
          ST_ARMED: begin
            // Waiting for the converter clock edge aligns the start to it,
            // so the sample point stays a fixed number of converter cycles on
            if (conv_tick) begin
              state <= ST_CONV;
              cnt <= 5'h00;
              conv_len <= first_done ? CONV_LEN[4:0] : FIRST_LEN[4:0];
            end
          end
          ST_CONV: begin
            // A start written mid-conversion in auto mode is queued, not lost
            if (auto_trigger_enable && start_write) begin
              pending <= 1'b1;
            end
            if (conv_tick) begin
              cnt <= cnt + 5'h01;
              // The first conversion samples late to let the analog part settle
              if (cnt == (first_done ? `SH_NORMAL : `SH_FIRST)) begin
                sample_hold <= 1'b1;
              end
            end
            if (last_cycle) begin
              first_done <= 1'b1;
              // Result saturation at full scale is the analog core's job
              result_low_register <= sar_code[7:0];
              // Result is always right adjusted; no left-adjust presentation
              result_high_register <= {6'h00, sar_code[9:8]};
              done_irq_pulse <= 1'b1;
              sleep_started <= 1'b0;
              // Free run: next conversion starts at the next converter clock tick with selection just copied
              if (auto_trigger_enable && (trigger_edge || pending)) begin
                state <= ST_ARMED;
                pending <= 1'b0;
              end else begin
                state <= ST_IDLE;
                start_conversion_bit <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/adc_sequencer_chk.sv
`default_nettype none
module adc_chk (
  // Host side
  input wire logic mclk, rst, sel_write, start_write, converter_enable,
  input wire logic [7:0] sel_wdata, selection_register,
  // Converter side
  input wire logic [3:0] channel_select_bits,
  input wire logic [1:0] reference_select_bits,
  input wire logic start_conversion_bit, conversion_done_flag, done_irq_pulse,
  input wire logic [7:0] result_low_register, result_high_register
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [5:0] app = {reference_select_bits, channel_select_bits};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sel_track_a: assert property (converter_enable && !start_conversion_bit
    && $stable(selection_register) |-> app == {selection_register[7:6], selection_register[3:0]})
    else $error("idle selection not applied");
  sel_freeze_a: assert property ($changed(app) && start_conversion_bit
    && $past(start_conversion_bit, 4) |-> ##[0:8] done_irq_pulse) else $error("selection moved");
  start_busy_a: assert property (start_write && converter_enable && !start_conversion_bit
    |=> start_conversion_bit) else $error("start not taken");
  busy_end_a: assert property ($fell(start_conversion_bit) && converter_enable
    |-> done_irq_pulse) else $error("busy ended without completion");
  irq_flag_a: assert property (done_irq_pulse
    |-> conversion_done_flag ##1 !done_irq_pulse) else $error("completion pulse wrong");
  result_hold_a: assert property (!done_irq_pulse
    |-> $stable({result_high_register, result_low_register})) else $error("result moved");
  result_pad_a: assert property (result_high_register[7:2] == 6'h00)
    else $error("result high padding set");
  sel_read_a: assert property (sel_write
    |=> selection_register == ($past(sel_wdata) & 8'hcf)) else $error("readback wrong");
endmodule
bind adc_sequencer adc_chk chk (.*);
`default_nettype wire

// ### dv/analog_core_model.sv
`default_nettype none
module analog_core_model (
  // Clock, reset, sample strobe and applied selection
  input wire logic mclk, rst, sh,
  input wire logic [3:0] ch,
  input wire logic [1:0] rf,
  // Converter clock and code
  output logic conv_tick,
  output logic [9:0] sar_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  // Code is held from the sample point, so a late mux change cannot leak in
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      sar_code <= 10'h3ff;
    end else begin
      div <= div + 2'h1;
      if (sh) begin
        sar_code <= (ch == 4'hf) ? 10'h000 : {rf, 4'h0, ch};
      end
    end
  end
  assign conv_tick = (div == 2'h3);
endmodule
`default_nettype wire

// ### dv/tb_adc_selection_sequencing.sv
`default_nettype none
module tb_adc_selection_sequencing;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, tick, sw = 0, st = 0, en = 1, dc = 0, slp = 0, hlt = 0;
  logic [7:0] wd = 8'h00, sel, rl, rh;
  logic [9:0] code;
  logic [3:0] ch;
  logic [1:0] rf;
  logic sh, busy, flag, irq;
  int n_fail = 0, n_checks = 0;
  // Default lengths: the sample points are fixed for 13 and 25 converter cycles
  // Auto trigger stays off, so no window arises; results after a reference switch
  // are only compared, never used as measurements
  adc_sequencer dut (.mclk(mclk), .rst(rst), .conv_tick(tick),
    .sel_write(sw), .sel_wdata(wd), .selection_register(sel), .converter_enable(en),
    .start_write(st), .auto_trigger_enable(1'b0), .trigger_edge(1'b0), .done_clear(dc),
    .sleep_noise_or_idle(slp), .cpu_halted(hlt), .sar_code(code), .channel_select_bits(ch),
    .reference_select_bits(rf), .sample_hold(sh), .start_conversion_bit(busy),
    .conversion_done_flag(flag), .done_irq_pulse(irq), .result_low_register(rl),
    .result_high_register(rh));
  analog_core_model core (.mclk(mclk), .rst(rst), .sh(sh), .ch(ch), .rf(rf),
    .conv_tick(tick), .sar_code(code));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(negedge mclk) {sw, wd} = {1'b1, v};
    @(negedge mclk) sw = 0;
  endtask
  task automatic go();
    @(negedge mclk) st = 1;
    @(negedge mclk) st = 0;
    chk("busy", {9'h0, busy}, 10'h001);
  endtask
  // Bounded wait: a lost completion must end as a mismatch, not a hang
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge mclk);
    chk("done", {8'h0, irq, flag}, 10'h003);
  endtask
  task automatic t_lock();
    wr(8'h41);
    go();
    repeat (8) @(negedge mclk);
    wr(8'hc2);
    @(negedge mclk);
    chk("lock", {4'h0, rf, ch}, 10'h011);
    wait_irq();
    chk("old", {rh[1:0], rl}, 10'h101);
    chk("new", {4'h0, rf, ch}, 10'h032);
  endtask
  task automatic t_codes();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 2'h0, 4'hf - i[3:0]};
      wr(v | 8'h30);
      chk("sel", {2'h0, sel}, {2'h0, v});
      @(negedge mclk);
      chk("mux", {4'h0, rf, ch}, {4'h0, v[7:6], v[3:0]});
      go();
      wait_irq();
      chk("code", {rh[1:0], rl}, i == 0 ? 10'h000 : {v[7:6], 4'h0, v[3:0]});
      chk("idle", {9'h0, busy}, 10'h000);
    end
  endtask
  task automatic t_sleep();
    @(negedge mclk) dc = 1;
    @(negedge mclk) {dc, slp, hlt} = 3'b011;
    chk("clr", {9'h0, flag}, 10'h000);
    wait_irq();
    chk("slp", {rh[1:0], rl}, 10'h30c);
    {slp, hlt} = 2'b00;
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst = 0;
    t_lock();
    t_codes();
    t_sleep();
    end_of_test();
  end
  initial begin
    #60000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
